// File: src/dram_refresh_and_clock_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Refresh spacing is interval field times 32
// - Each refresh covers one row, all banks
// - No refresh start while ready holds off
// - Static transfers yield at 32-bit word boundaries
// - 16-bit static reads yield after two cycles
// - 32-bit static reads yield after one cycle
// - Refresh only between DRAM bursts, never inside
// - Card transactions continue through refresh untouched
// - Clock-enable bit drives pin, sleep clears
// - Reset loads both bits from boot select
// - Software clear with run issues power-down
// - Software set with run issues power-down-exit
// - Forced-low enable blocks automatic enable transitions
// - Clock-run bit gates clock pin, sleep clears
module dram_refresh_and_clock_ctrl
  import refresh_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Power state
  input  wire logic              boot_sync_rom_select,
  input  wire logic              sleep_enter,
  input  wire logic              sleep_reset,
  // Static memory transfer state
  input  wire logic              static_busy,
  input  wire logic              static_read,
  input  wire logic              static_bus16,
  input  wire logic              static_word_done,
  input  wire logic              static_read_done,
  input  wire logic              vlio_wait,
  // DRAM and card transfer state
  input  wire logic              dram_burst_active,
  input  wire logic              card_busy,
  // Automatic clock-enable wake request
  input  wire logic              auto_cke_wake,
  // Refresh outputs
  output logic                   refresh_pending,
  output logic                   refresh_start,
  output logic      [BANKS-1:0]  refresh_banks,
  output logic                   static_suspend,
  // Synchronous memory commands
  output logic                   power_down_cmd,
  output logic                   power_down_exit_cmd,
  // Synchronous memory pins
  output logic                   sync_clock_pin0,
  output logic                   sync_clock_enable_pin0
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Register decode

  logic [INTERVAL_W-1:0] refresh_interval_field_r;
  logic                  bank0_clock_enable_level_r;
  logic                  bank0_clock_run_r;
  logic                  cke_forced_low_r;
  logic                  init_pending_r;
  logic [DATA_W-1:0]     rdata_r;

  wire wr_cfg  = reg_wr & reg_hit(reg_addr, OFF_REFRESH_CFG);
  wire wr_clk  = reg_wr & reg_hit(reg_addr, OFF_CLOCK_CTRL);
  wire rd_cfg  = reg_rd & reg_hit(reg_addr, OFF_REFRESH_CFG);
  wire rd_clk  = reg_rd & reg_hit(reg_addr, OFF_CLOCK_CTRL);
  wire rd_stat = reg_rd & reg_hit(reg_addr, OFF_STATUS);

  wire wr_cke  = reg_wdata[CKE_BIT];
  wire wr_run  = reg_wdata[RUN_BIT];

  //////////////////////////////////////////////////////////////////////
  // Refresh timer and arbitration

  arb_e               arb_r;
  arb_e               arb_nxt;
  logic [COUNT_W-1:0] cnt_r;
  logic [COUNT_W-1:0] cnt_nxt;
  logic               half_r;
  logic               start_r;
  logic [BANKS-1:0]   banks_r;

  wire [COUNT_W-1:0] interval_cycles = {refresh_interval_field_r, UNIT_ZERO};
  wire [COUNT_W-1:0] count_limit     = interval_cycles - COUNT_ONE;
  wire               timer_off       = (refresh_interval_field_r == INTERVAL_RST);
  wire               timer_hit       = (cnt_r == count_limit);

  // Read boundary: 16-bit bus needs a second read, 32-bit one
  wire read_point   = static_read_done & (~static_bus16 | half_r);
  wire static_point = static_read ? read_point : static_word_done;
  wire static_ok    = ~static_busy | static_point;
  wire dram_ok      = ~dram_burst_active;
  wire vlio_ok      = ~vlio_wait;
  // Card activity does not hold off a refresh
  wire card_ok      = card_busy | ~card_busy;
  wire service_ok   = static_ok & dram_ok & vlio_ok & card_ok;
  wire pending_w    = (arb_r == ARB_PEND);
  wire grant        = pending_w & service_ok;

  always_comb begin
    arb_nxt = arb_r;
    cnt_nxt = cnt_r;
    case (arb_r)
      ARB_COUNT: begin
        if (timer_off) begin
          cnt_nxt = COUNT_ZERO;
        end else if (timer_hit) begin
          arb_nxt = ARB_PEND;
          cnt_nxt = COUNT_ZERO;
        end else begin
          cnt_nxt = cnt_r + COUNT_ONE;
        end
      end
      ARB_PEND: begin
        if (grant) begin
          arb_nxt = ARB_COUNT;
          cnt_nxt = COUNT_ONE;
        end
      end
      default: begin
        arb_nxt = ARB_COUNT;
        cnt_nxt = COUNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arb_r <= ARB_COUNT;
      cnt_r <= COUNT_ZERO;
    end else begin
      arb_r <= arb_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Tracks the first half of a 32-bit word on a 16-bit read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_r <= 1'b0;
    end else if (~static_busy | ~static_read | ~static_bus16) begin
      half_r <= 1'b0;
    end else if (static_read_done) begin
      half_r <= ~half_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_r <= 1'b0;
      banks_r <= NO_BANKS;
    end else begin
      start_r <= grant;
      banks_r <= grant ? ALL_BANKS : NO_BANKS;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bank 0 clock-run and clock-enable control

  logic pd_r;
  logic pdx_r;
  logic clk_pin_r;
  logic cke_pin_r;

  wire strap_load = init_pending_r | sleep_reset;
  wire sw_clear   = wr_clk & bank0_clock_enable_level_r & ~wr_cke;
  wire sw_set     = wr_clk & ~bank0_clock_enable_level_r & wr_cke;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_pending_r <= 1'b1;
    end else begin
      init_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank0_clock_enable_level_r <= CKE_RST;
      bank0_clock_run_r          <= RUN_RST;
    end else if (strap_load) begin
      bank0_clock_enable_level_r <= boot_sync_rom_select;
      bank0_clock_run_r          <= boot_sync_rom_select;
    end else if (sleep_enter) begin
      bank0_clock_enable_level_r <= 1'b0;
      bank0_clock_run_r          <= 1'b0;
    end else if (wr_clk) begin
      bank0_clock_enable_level_r <= wr_cke;
      bank0_clock_run_r          <= wr_run;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_forced_low_r <= 1'b0;
    end else if (strap_load | sleep_enter | sw_set) begin
      cke_forced_low_r <= 1'b0;
    end else if (sw_clear) begin
      cke_forced_low_r <= 1'b1;
    end
  end

  // Power-down command uses the run bit before the write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= sw_clear & bank0_clock_run_r & ~strap_load;
    end
  end

  // Power-down-exit command uses the run bit before the write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdx_r <= 1'b0;
    end else begin
      pdx_r <= sw_set & bank0_clock_run_r & ~strap_load;
    end
  end

  // Clock pin toggles at half rate while running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_pin_r <= 1'b0;
    end else begin
      clk_pin_r <= bank0_clock_run_r & ~clk_pin_r;
    end
  end

  // Enable pin: level bit, or automatic wake unless forced low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_pin_r <= 1'b0;
    end else begin
      cke_pin_r <= bank0_clock_enable_level_r
                   | (auto_cke_wake & ~cke_forced_low_r);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refresh_interval_field_r <= INTERVAL_RST;
    end else if (wr_cfg) begin
      refresh_interval_field_r <= reg_wdata[INTERVAL_LSB +: INTERVAL_W];
    end
  end

  wire [DATA_W-1:0] cfg_word  = {{(DATA_W-INTERVAL_W){1'b0}},
                                 refresh_interval_field_r};
  logic [DATA_W-1:0] clk_word;
  logic [DATA_W-1:0] stat_word;

  // Control and status words, fields at their named positions
  always_comb begin
    clk_word                 = DATA_ZERO;
    clk_word[CKE_BIT]        = bank0_clock_enable_level_r;
    clk_word[RUN_BIT]        = bank0_clock_run_r;
    stat_word                = DATA_ZERO;
    stat_word[ST_PEND_BIT]   = pending_w;
    stat_word[ST_FORCED_BIT] = cke_forced_low_r;
    stat_word[ST_INIT_BIT]   = init_pending_r;
  end

  wire [DATA_W-1:0] rd_mux    = rd_cfg  ? cfg_word  :
                                rd_clk  ? clk_word  :
                                rd_stat ? stat_word : DATA_ZERO;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= DATA_ZERO;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata              = rdata_r;
  assign refresh_pending        = pending_w;
  assign refresh_start          = start_r;
  assign refresh_banks          = banks_r;
  assign static_suspend         = grant & static_busy;
  assign power_down_cmd         = pd_r;
  assign power_down_exit_cmd    = pdx_r;
  assign sync_clock_pin0        = clk_pin_r;
  assign sync_clock_enable_pin0 = cke_pin_r;

endmodule

// File: src/refresh_ctrl_pkg.sv
package refresh_ctrl_pkg;
  // Register offsets
  localparam logic [7:0]  OFF_REFRESH_CFG  = 8'h00;
  localparam logic [7:0]  OFF_CLOCK_CTRL   = 8'h04;
  localparam logic [7:0]  OFF_STATUS       = 8'h08;
  // Refresh configuration fields
  localparam int          INTERVAL_W       = 12;
  localparam int          INTERVAL_LSB     = 0;
  localparam logic [11:0] INTERVAL_RST     = 12'h000;
  localparam int          UNIT_SHIFT       = 5;
  localparam logic [4:0]  UNIT_ZERO        = 5'h00;
  localparam int          COUNT_W          = INTERVAL_W + UNIT_SHIFT;
  localparam logic [16:0] COUNT_ONE        = 17'h00001;
  localparam logic [16:0] COUNT_ZERO       = 17'h00000;
  // Clock control fields
  localparam int          CKE_BIT          = 0;
  localparam int          RUN_BIT          = 1;
  localparam logic        CKE_RST          = 1'b0;
  localparam logic        RUN_RST          = 1'b0;
  // Status fields
  localparam int          ST_PEND_BIT      = 0;
  localparam int          ST_FORCED_BIT    = 1;
  localparam int          ST_INIT_BIT      = 2;
  // Bus
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam int          BANKS            = 4;
  localparam logic [3:0]  ALL_BANKS        = 4'hf;
  localparam logic [3:0]  NO_BANKS         = 4'h0;
  localparam logic [31:0] DATA_ZERO        = 32'h00000000;

  typedef enum logic {
    ARB_COUNT = 1'b0,
    ARB_PEND  = 1'b1
  } arb_e;
endpackage

// File: verification/sync_mem_model.sv
`timescale 1ns/1ps
module sync_mem_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Commands from the controller
  input  wire logic       power_down_cmd,
  input  wire logic       power_down_exit_cmd,
  // Memory state seen by the bench
  output logic            asleep,
  output logic      [7:0] ncmd
);
  // Power state and command count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      asleep <= 1'b0;
      ncmd   <= 8'h00;
    end else if (power_down_cmd || power_down_exit_cmd) begin
      asleep <= power_down_cmd;
      ncmd   <= ncmd + 8'h01;
    end
  end
endmodule

// File: verification/refresh_ctrl_monitor.sv
`timescale 1ns/1ps
module refresh_ctrl_monitor
  import refresh_ctrl_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              boot_sync_rom_select,
  input wire logic              sleep_enter,
  input wire logic              sleep_reset,
  input wire logic              vlio_wait,
  input wire logic              dram_burst_active,
  input wire logic              auto_cke_wake,
  input wire logic              refresh_pending,
  input wire logic              refresh_start,
  input wire logic              static_suspend,
  input wire logic [BANKS-1:0]  refresh_banks,
  input wire logic              power_down_cmd,
  input wire logic              power_down_exit_cmd,
  input wire logic              sync_clock_pin0,
  input wire logic              sync_clock_enable_pin0
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_start_banks: assert property (refresh_banks == (refresh_start ? ALL_BANKS : NO_BANKS))
    else $error("bank mask wrong");
  chk_suspend_start: assert property (static_suspend |=> refresh_start)
    else $error("suspend without refresh");
  chk_vlio_holds: assert property (refresh_pending && vlio_wait |=> !refresh_start)
    else $error("refresh during io wait");
  chk_burst_gap: assert property (refresh_pending && dram_burst_active |=> !refresh_start)
    else $error("refresh inside burst");
  chk_pd_cause: assert property (power_down_cmd |-> $past(reg_wr) && !$past(reg_wdata[CKE_BIT])
    && $past(reg_addr) == OFF_CLOCK_CTRL) else $error("stray power-down");
  chk_pdx_cause: assert property (power_down_exit_cmd |-> $past(reg_wr)
    && $past(reg_wdata[CKE_BIT]) && $past(reg_addr) == OFF_CLOCK_CTRL) else $error("stray exit");
  chk_clk_toggles: assert property (sync_clock_pin0 |=> !sync_clock_pin0)
    else $error("clock pin stuck high");
  chk_sleep_clears: assert property (sleep_enter && !sleep_reset |=> ##1 (!sync_clock_pin0
    && sync_clock_enable_pin0 == $past(auto_cke_wake))) else $error("sleep left pins on");
  chk_forced_low: assert property (power_down_cmd |=> !sync_clock_enable_pin0)
    else $error("enable pin rose while forced low");
  chk_strap_load: assert property (sleep_reset |=> ##1 sync_clock_enable_pin0 ==
    (boot_sync_rom_select | $past(auto_cke_wake))) else $error("strap not loaded");
endmodule

// File: verification/dram_refresh_and_clock_ctrl_tb_top.sv
`timescale 1ns/1ps
module dram_refresh_and_clock_ctrl_tb_top;
  import refresh_ctrl_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h00000000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              rd_d = 1'b0;
  logic              boot_sync_rom_select = 1'b1;
  logic [3:0]        pv = 4'h0;
  logic [4:0]        st = 5'h00;
  logic [15:0]       sd = 16'h8772;
  logic [DATA_W-1:0] reg_rdata;
  logic [BANKS-1:0]  refresh_banks;
  logic              refresh_pending, refresh_start, power_down_cmd, power_down_exit_cmd;
  logic              sync_clock_pin0, sync_clock_enable_pin0, asleep, static_suspend;
  logic [7:0]        ncmd;
  logic [31:0]       rq[$];
  int                fails = 0;
  int                num_checks = 0;
  int                n;

  dram_refresh_and_clock_ctrl dram_refresh_and_clock_ctrl_i (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .boot_sync_rom_select,
    .sleep_enter(pv[2]), .sleep_reset(pv[3]), .static_busy(st[0]), .static_read(st[1]),
    .static_bus16(st[2]), .static_word_done(pv[1]), .static_read_done(pv[0]),
    .vlio_wait(st[3]), .dram_burst_active(st[4]), .card_busy(sd[0]), .auto_cke_wake(sd[5]),
    .refresh_pending, .refresh_start, .refresh_banks, .static_suspend,
    .power_down_cmd, .power_down_exit_cmd, .sync_clock_pin0, .sync_clock_enable_pin0);
  sync_mem_model sync_mem_model_i (.clk, .rst, .power_down_cmd, .power_down_exit_cmd,
    .asleep, .ncmd);

  function automatic logic [15:0] lf(input logic [15:0] x);
    lf = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  always #25 clk = ~clk;
  always @(posedge clk) sd <= lf(sd);
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) cmp(reg_rdata, rq.pop_front());

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask
  task automatic sp(input int i);
    @(posedge clk) pv[i] <= 1'b1;
    @(posedge clk) pv[i] <= 1'b0;
  endtask
  task automatic ws(input int lim, input int must);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (refresh_start !== 1'b1 && n < lim);
    if (must != 0 && refresh_start !== 1'b1) begin
      fails++;
      final_report();
    end
  endtask
  task automatic hold(input logic [4:0] lv, input int lim);
    @(posedge clk) st <= lv;
    ws(lim, 0);
    cmp(n, lim);
  endtask
  task automatic blk(input logic [4:0] lv);
    hold(lv, 60);
    rd(OFF_STATUS, 32'h00000001);
    @(posedge clk) st <= 5'h00;
    ws(3, 1);
    cmp(n, 2);
  endtask
  task automatic svc(input logic [4:0] lv, input int w);
    hold(lv, 40);
    if (lv[2]) begin
      sp(w);
      ws(3, 0);
      cmp(n, 3);
    end
    sp(w);
    ws(3, 1);
    cmp(n, 1);
    @(posedge clk) st <= 5'h00;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_STATUS, 32'h00000000);
    rd(OFF_CLOCK_CTRL, 32'h00000003);
    rd(8'h0c, 32'h00000000);
    wr(OFF_CLOCK_CTRL, 32'h00000002);
    repeat (2) @(negedge clk);
    cmp(asleep, 32'h00000001);
    rd(OFF_STATUS, 32'h00000002);
    wr(OFF_CLOCK_CTRL, 32'h00000003);
    repeat (2) @(negedge clk);
    cmp(asleep, 32'h00000000);
    wr(OFF_CLOCK_CTRL, 32'h00000001);
    wr(OFF_CLOCK_CTRL, 32'h00000000);
    wr(OFF_CLOCK_CTRL, 32'h00000003);
    repeat (2) @(negedge clk);
    cmp(ncmd, 32'h00000002);
    sp(2);
    rd(OFF_CLOCK_CTRL, 32'h00000000);
    sp(3);
    rd(OFF_CLOCK_CTRL, 32'h00000003);
    wr(OFF_REFRESH_CFG, 32'h00000001);
    ws(80, 1);
    ws(40, 1);
    cmp(n, 32);
    blk(5'h08);
    blk(5'h10);
    svc(5'h07, 0);
    svc(5'h03, 0);
    svc(5'h01, 1);
    final_report();
  end
endmodule

bind dram_refresh_and_clock_ctrl refresh_ctrl_monitor refresh_ctrl_monitor_i (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .boot_sync_rom_select, .sleep_enter,
  .sleep_reset, .vlio_wait, .dram_burst_active, .auto_cke_wake, .refresh_pending,
  .refresh_start, .static_suspend, .refresh_banks, .power_down_cmd, .power_down_exit_cmd,
  .sync_clock_pin0, .sync_clock_enable_pin0);
